// File: hdl/drvso_pkg.sv
package drvso_pkg;
  // --------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------
  localparam logic [11:0] REG_CFG = 12'h000;
  localparam logic [11:0] REG_TSEL = 12'h004;
  localparam logic [11:0] REG_RSEL = 12'h008;
  localparam logic [11:0] REG_THR1 = 12'h00C;
  localparam logic [11:0] REG_THR2 = 12'h010;
  localparam logic [11:0] REG_FMAX = 12'h014;
  localparam logic [11:0] REG_TQ = 12'h018;
  localparam logic [11:0] REG_STAT = 12'h01C;
  // --------------------------------------------------------------
  // fields and values after reset
  // --------------------------------------------------------------
  localparam int RELAY_POL_BIT = 5;
  localparam int CM_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0020;
  localparam logic [29:0] TSEL_RST = 30'h0000_0000;
  localparam logic [5:0] RSEL_RST = 6'h05;
  localparam logic [15:0] FMAX_RST = 16'h1770;
  localparam logic [7:0] TQ_MAX_SMALL = 8'hC8;
  localparam logic [7:0] TQ_MAX_LARGE = 8'hB4;
  localparam logic [15:0] FON_DIV = 16'h0064;
  localparam logic [15:0] FOFF_DIV = 16'h0032;
  // --------------------------------------------------------------
  // output function codes and control methods
  // --------------------------------------------------------------
  localparam logic [5:0] FN_RUN = 6'h00;
  localparam logic [5:0] FN_FA1 = 6'h01;
  localparam logic [5:0] FN_FA2 = 6'h02;
  localparam logic [5:0] FN_ALARM = 6'h05;
  localparam logic [5:0] FN_FA3 = 6'h06;
  localparam logic [5:0] FN_OTQ = 6'h07;
  localparam logic [5:0] FN_FA4 = 6'h18;
  localparam logic [5:0] FN_FA5 = 6'h19;
  localparam logic [3:0] CM_SLV = 4'h3;
  localparam logic [3:0] CM_SLV0 = 4'h4;
  localparam logic [3:0] CM_SENSOR = 4'h5;
  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic dcbrake;
    logic trip;
    logic accel;
    logic decel;
    logic reverse;
    logic [15:0] fout;
    logic [15:0] fset;
    logic [9:0] torque;
  } drvso_drive_s;
  typedef struct packed {
    logic fa1;
    logic fa2;
    logic fa3;
    logic fa4;
    logic fa5;
    logic torque_over_limit;
  } drvso_flags_s;
endpackage

// File: hdl/drvso_top.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// What this block does
// [RL1] each transistor output has own polarity: 00 direct, 01 inverted, reset 00
// [RL2] relay polarity 00 first contact NO, 01 reversed; default 01
// [RL3] alarm on relay: polarity 00 fault closes first contact, 01 opens it
// [RL4] relay is changeover: second contact always opposite first; reset as unpowered
// [RL5] function code 00 shows running indicator while drive runs
// [RL6] running indicator also held during DC injection braking
// [RL7] acceleration threshold 0 suppresses arrival during acceleration
// [RL8] deceleration threshold 0 suppresses arrival during deceleration
// [RL9] arrival functions 01, 02, 06, 24, 25 selectable
// [RL10] arrival sets at target minus 1% max, clears below minus 2%
// [RL11] equal-only: accel on -1% off +2%; decel on +1% off -2%
// [RL12] constant speed arrival compares against active frequency command
// [RL13] exceeded flags 02 and 24 use first and second threshold pairs
// [RL14] equal-only flags 06 and 25 use first and second pairs
// [RL15] overtorque 07 when torque magnitude exceeds level of current quadrant
// [RL16] torque levels 0..200 small or 0..180 large rating, default maximum
// [RL17] overtorque meaningful only under vector control methods
// [RL18] outside hoist control brakes on arrival, releases on overtorque
// [RL19] relay function selection defaults to alarm code 05
// [RL20] flags registered in one domain; reset drives outputs inactive
// [RL21] hysteresis is fraction of max frequency; each comparator keeps state
module drvso_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [11:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_LARGE_RATING,
  input wire drvso_pkg::drvso_drive_s I_DRIVE,
  output logic [4:0] O_TR,
  output logic O_RELAY_FIRST,
  output logic O_RELAY_SECOND
);
  import drvso_pkg::*;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] bmerge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      bmerge[8*b+:8] = s[b] ? w[8*b+:8] : o[8*b+:8];
    end
  endfunction

  function automatic logic [31:0] tclamp(input logic [31:0] v,
      input logic [7:0] mx);
    for (int b = 0; b < 4; b++) begin
      tclamp[8*b+:8] = (v[8*b+:8] > mx) ? mx : v[8*b+:8];
    end
  endfunction

  // eq selects the equal-only band, dn the deceleration side
  function automatic logic arr_next(input logic q, input logic [15:0] f,
      input logic [15:0] t, input logic [15:0] fon,
      input logic [15:0] foff, input logic eq, input logic dn);
    logic [16:0] f_on;
    logic [16:0] f_off;
    logic [16:0] t_on;
    logic [16:0] t_off;
    logic r;
    f_on = {1'b0, f} + {1'b0, fon};
    f_off = {1'b0, f} + {1'b0, foff};
    t_on = {1'b0, t} + {1'b0, fon};
    t_off = {1'b0, t} + {1'b0, foff};
    r = q;
    if (!eq) begin
      if (f_on >= {1'b0, t}) r = 1'b1; // RL10
      else if (f_off < {1'b0, t}) r = 1'b0;
    end else if (!dn) begin
      if ({1'b0, f} > t_off) r = 1'b0; // RL11
      else if (f_on >= {1'b0, t}) r = 1'b1;
    end else begin
      if (f_off < {1'b0, t}) r = 1'b0; // RL11
      else if ({1'b0, f} <= t_on) r = 1'b1;
    end
    arr_next = r;
  endfunction

  function automatic logic fn_sel(input logic [5:0] code,
      input drvso_flags_s fl, input logic run, input logic trip);
    logic r;
    r = 1'b0;
    case (code)
      FN_RUN: r = run; // RL5
      FN_FA1: r = fl.fa1; // RL9
      FN_FA2: r = fl.fa2;
      FN_ALARM: r = trip;
      FN_FA3: r = fl.fa3;
      FN_OTQ: r = fl.torque_over_limit;
      FN_FA4: r = fl.fa4;
      FN_FA5: r = fl.fa5;
      default: r = 1'b0;
    endcase
    fn_sel = r;
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [29:0] tsel_q;
  logic [5:0] rsel_q;
  logic [31:0] thr_q [2];
  logic [15:0] fmax_q;
  logic [31:0] tq_q;
  logic large_q;
  logic [7:0] tq_max;
  logic wr;
  logic mapped;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  drvso_flags_s flags;
  logic [31:0] tsel_w;
  logic [31:0] rsel_w;
  logic [31:0] fmax_w;

  assign tsel_w = bmerge({2'b00, tsel_q}, I_PWDATA, I_PSTRB);
  assign rsel_w = bmerge({26'h000_0000, rsel_q}, I_PWDATA, I_PSTRB);
  assign fmax_w = bmerge({16'h0000, fmax_q}, I_PWDATA, I_PSTRB);
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign tq_max = large_q ? TQ_MAX_LARGE : TQ_MAX_SMALL;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_PRDATA = prdata_q;

  // rating is a strap: taken while reset is held, fixed afterwards
  always_ff @(posedge I_CLK) begin
    if (I_RST) large_q <= I_LARGE_RATING;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cfg_q <= CFG_RST; // RL1 RL2
      tsel_q <= TSEL_RST;
      rsel_q <= RSEL_RST; // RL19
      thr_q[0] <= 32'h0000_0000;
      thr_q[1] <= 32'h0000_0000;
      fmax_q <= FMAX_RST;
      tq_q <= {4{I_LARGE_RATING ? TQ_MAX_LARGE : TQ_MAX_SMALL}}; // RL16
    end else if (wr) begin
      case (I_PADDR)
        REG_CFG: cfg_q <= bmerge(cfg_q, I_PWDATA, I_PSTRB);
        REG_TSEL: tsel_q <= tsel_w[29:0];
        REG_RSEL: rsel_q <= rsel_w[5:0];
        REG_THR1: thr_q[0] <= bmerge(thr_q[0], I_PWDATA, I_PSTRB);
        REG_THR2: thr_q[1] <= bmerge(thr_q[1], I_PWDATA, I_PSTRB);
        REG_FMAX: fmax_q <= fmax_w[15:0];
        // out-of-range levels saturate at the rating maximum
        REG_TQ: tq_q <= tclamp(bmerge(tq_q, I_PWDATA, I_PSTRB),
                               tq_max); // RL16
        default: ;
      endcase
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_d = 32'h0000_0000;
    case (I_PADDR)
      REG_CFG: rd_d = cfg_q;
      REG_TSEL: rd_d = {2'b00, tsel_q};
      REG_RSEL: rd_d = {26'h000_0000, rsel_q};
      REG_THR1: rd_d = thr_q[0];
      REG_THR2: rd_d = thr_q[1];
      REG_FMAX: rd_d = {16'h0000, fmax_q};
      REG_TQ: rd_d = tq_q;
      REG_STAT: rd_d = {20'h0_0000, O_RELAY_FIRST, O_TR, flags};
      default: mapped = 1'b0;
    endcase
  end

  // read data latched in setup so the access phase needs no wait
  always_ff @(posedge I_CLK) begin
    if (I_RST) prdata_q <= 32'h0000_0000;
    else if (I_PSEL && !I_PENABLE) prdata_q <= rd_d;
  end

  // --------------------------------------------------------------
  // arrival comparators
  // --------------------------------------------------------------
  logic [15:0] fon;
  logic [15:0] foff;
  logic fa1_q;
  logic [1:0] fx_q;
  logic [1:0] fe_q;
  logic run_ind;

  assign fon = fmax_q / FON_DIV; // RL21
  assign foff = fmax_q / FOFF_DIV; // RL21
  assign run_ind = I_DRIVE.run || I_DRIVE.dcbrake; // RL6

  always_ff @(posedge I_CLK) begin
    if (I_RST || !I_DRIVE.run) fa1_q <= 1'b0;
    else fa1_q <= arr_next(fa1_q, I_DRIVE.fout, I_DRIVE.fset, fon,
                           foff, 1'b0, 1'b0); // RL12
  end

  for (genvar k = 0; k < 2; k++) begin : g_pair
    logic [15:0] ta;
    logic [15:0] td;
    assign ta = thr_q[k][15:0];
    assign td = thr_q[k][31:16];
    always_ff @(posedge I_CLK) begin
      if (I_RST || !I_DRIVE.run) begin
        fx_q[k] <= 1'b0;
        fe_q[k] <= 1'b0;
      end else if (I_DRIVE.accel) begin
        if (ta == 16'h0000) begin
          fx_q[k] <= 1'b0; // RL7
          fe_q[k] <= 1'b0;
        end else begin
          fx_q[k] <= arr_next(fx_q[k], I_DRIVE.fout, ta, fon, foff,
                              1'b0, 1'b0); // RL13
          fe_q[k] <= arr_next(fe_q[k], I_DRIVE.fout, ta, fon, foff,
                              1'b1, 1'b0); // RL14
        end
      end else if (I_DRIVE.decel) begin
        if (td == 16'h0000) begin
          fx_q[k] <= 1'b0; // RL8
          fe_q[k] <= 1'b0;
        end else begin
          fx_q[k] <= arr_next(fx_q[k], I_DRIVE.fout, td, fon, foff,
                              1'b0, 1'b1); // RL13
          fe_q[k] <= arr_next(fe_q[k], I_DRIVE.fout, td, fon, foff,
                              1'b1, 1'b1); // RL14
        end
      end
    end
  end

  // --------------------------------------------------------------
  // overtorque
  // --------------------------------------------------------------
  logic [9:0] tmag;
  logic [7:0] tlev;
  logic vec_on;
  logic otq_q;

  assign tmag = I_DRIVE.torque[9] ? (~I_DRIVE.torque + 10'h001)
                                  : I_DRIVE.torque;
  assign vec_on = cfg_q[CM_LSB+:4] == CM_SLV ||
                  cfg_q[CM_LSB+:4] == CM_SLV0 ||
                  cfg_q[CM_LSB+:4] == CM_SENSOR;

  always_comb begin
    unique case ({I_DRIVE.reverse, I_DRIVE.torque[9]})
      2'b00: tlev = tq_q[7:0]; // RL15
      2'b10: tlev = tq_q[15:8];
      2'b11: tlev = tq_q[23:16];
      2'b01: tlev = tq_q[31:24];
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) otq_q <= 1'b0;
    else otq_q <= tmag > {2'b00, tlev}; // RL15
  end

  // outside vector control the estimate is junk, so hold it low
  assign flags = '{fa1: fa1_q, fa2: fx_q[0], fa3: fe_q[0],
                   fa4: fx_q[1], fa5: fe_q[1],
                   torque_over_limit: otq_q && vec_on}; // RL17

  // --------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------
  logic [4:0] tr_q;
  logic relay_first_q;
  logic relay_second_q;
  logic [4:0] tr_fn;
  logic relay_fn;

  for (genvar k = 0; k < 5; k++) begin : g_tr
    assign tr_fn[k] = fn_sel(tsel_q[6*k+:6], flags, run_ind,
                             I_DRIVE.trip);
  end
  assign relay_fn = fn_sel(rsel_q, flags, run_ind, I_DRIVE.trip);

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tr_q <= CFG_RST[4:0]; // RL20
      // unpowered contact state: first open, second closed
      relay_first_q <= 1'b0; // RL4
      relay_second_q <= 1'b1; // RL4
    end else begin
      tr_q <= tr_fn ^ cfg_q[4:0]; // RL1
      relay_first_q <= relay_fn ^ cfg_q[RELAY_POL_BIT]; // RL2 RL3
      relay_second_q <= !(relay_fn ^ cfg_q[RELAY_POL_BIT]); // RL4
    end
  end

  assign O_TR = tr_q;
  assign O_RELAY_FIRST = relay_first_q;
  assign O_RELAY_SECOND = relay_second_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_alarm;
    rsel_q == FN_ALARM && I_DRIVE.trip;
  endsequence
  sequence s_run_sel;
    tsel_q[5:0] == FN_RUN && !cfg_q[0];
  endsequence

  relay_changeover_a: assert property ( // RL4
    O_RELAY_FIRST != O_RELAY_SECOND) else $error("relay not changeover");
  tr_polarity_a: assert property ( // RL1
    (tr_fn[0] ^ cfg_q[0]) |=> O_TR[0]) else $error("tr polarity wrong");
  alarm_normal_a: assert property ( // RL3
    s_alarm and !cfg_q[RELAY_POL_BIT] |=> O_RELAY_FIRST && !O_RELAY_SECOND)
    else $error("alarm polarity 00 wrong");
  alarm_inverted_a: assert property ( // RL2
    s_alarm and cfg_q[RELAY_POL_BIT] |=> !O_RELAY_FIRST && O_RELAY_SECOND)
    else $error("alarm polarity 01 wrong");
  run_indicator_a: assert property ( // RL5
    s_run_sel and I_DRIVE.run |=> O_TR[0]) else $error("run not shown");
  dc_brake_a: assert property ( // RL6
    s_run_sel and I_DRIVE.dcbrake |=> O_TR[0]) else $error("dcb not shown");
  accel_suppress_a: assert property ( // RL7
    I_DRIVE.accel && thr_q[0][15:0] == 16'h0000 |=> !fx_q[0] && !fe_q[0])
    else $error("accel arrival not suppressed");
  decel_suppress_a: assert property ( // RL8
    I_DRIVE.decel && !I_DRIVE.accel && thr_q[0][31:16] == 16'h0000
    |=> !fx_q[0] && !fe_q[0]) else $error("decel arrival not suppressed");
  fa1_reach_a: assert property ( // RL10
    I_DRIVE.run && {1'b0, I_DRIVE.fout} + {1'b0, fon} >= {1'b0, I_DRIVE.fset}
    |=> fa1_q) else $error("constant speed arrival missed");
  torque_fwd_a: assert property ( // RL15
    !I_DRIVE.reverse && !I_DRIVE.torque[9] && tmag > {2'b00, tq_q[7:0]}
    |=> otq_q) else $error("forward overtorque missed");
  level_clamp_a: assert property ( // RL16
    tq_q[7:0] <= tq_max && tq_q[31:24] <= tq_max)
    else $error("torque level above maximum");
  otq_vector_a: assert property ( // RL17
    !vec_on |-> !flags.torque_over_limit) else $error("overtorque outside vector");
endmodule

// File: dv/drvso_hoist_model.sv
`timescale 1ns/1ns
module drvso_hoist_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_arrival,
  input wire logic i_overtorque,
  output logic o_brake_applied
);
  // ------------------------------------------------------------
  // brake latch of the hoist controller
  // ------------------------------------------------------------
  // resets to applied: a load must never hang on an open brake
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_brake_applied <= 1'b1;
    end else if (i_overtorque) begin
      o_brake_applied <= 1'b0;
    end else if (i_arrival) begin
      o_brake_applied <= 1'b1;
    end
  end
endmodule

// File: dv/drvso_top_tb.sv
`timescale 1ns/1ns
module drvso_top_tb;
  import drvso_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic I_LARGE_RATING = 1'b0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0000_0000;
  logic [3:0] I_PSTRB = 4'hF;
  logic [31:0] O_PRDATA;
  logic [31:0] rd;
  logic O_PREADY, O_PSLVERR, O_RELAY_FIRST, O_RELAY_SECOND, brake, er;
  logic [4:0] O_TR;
  drvso_drive_s drv = '0;
  int err_total = 0;
  int n_tests = 0;
  // arrival steps: decel, fout, expected outputs
  logic [21:0] fa_tab [7] = '{{1'b0, 16'h0B7B, 5'h00},
    {1'b0, 16'h0B7C, 5'h1E}, {1'b0, 16'h0C31, 5'h0A},
    {1'b0, 16'h0F64, 5'h0B}, {1'b1, 16'h0834, 5'h02},
    {1'b1, 16'h080C, 5'h06}, {1'b1, 16'h0757, 5'h00}};
  // quadrant steps: reverse, torque, expected overtorque
  logic [11:0] tq_tab [8] = '{{1'b0, 10'h029, 1'b1},
    {1'b0, 10'h028, 1'b0}, {1'b1, 10'h01F, 1'b1}, {1'b1, 10'h01E, 1'b0},
    {1'b1, 10'h3EB, 1'b1}, {1'b1, 10'h3EC, 1'b0}, {1'b0, 10'h3F5, 1'b1},
    {1'b0, 10'h3F6, 1'b0}};

  always #4 I_CLK = ~I_CLK;

  drvso_top drvso_top_inst (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_PADDR(I_PADDR), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_LARGE_RATING(I_LARGE_RATING), .I_DRIVE(drv), .O_TR(O_TR),
    .O_RELAY_FIRST(O_RELAY_FIRST), .O_RELAY_SECOND(O_RELAY_SECOND));

  drvso_hoist_model drvso_hoist_model_inst (.i_clk(I_CLK), .i_rst(I_RST),
    .i_arrival(O_TR[1]), .i_overtorque(O_TR[0]), .o_brake_applied(brake));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge I_CLK);
      if (O_PREADY === 1'b1) break;
    end
    if (i == 16) begin
      err_total++;
      conclude();
    end
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, ex, rd);
  endtask

  // two edges of pipeline plus margin, sampled mid-cycle
  task automatic ochk(input string nm, input logic [4:0] ex);
    repeat (4) @(posedge I_CLK);
    @(negedge I_CLK);
    chk(nm, 32'(ex), 32'(O_TR));
  endtask

  task automatic relchk(input logic first);
    repeat (3) @(posedge I_CLK);
    @(negedge I_CLK);
    chk("relay", 32'({first, ~first}), 32'({O_RELAY_FIRST, O_RELAY_SECOND}));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge I_CLK);
    I_RST <= 1'b0;
    relchk(1'b1);
    ochk("reset outputs", 5'h00);
    rchk("cfg", REG_CFG, 32'h0000_0020);
    rchk("tsel", REG_TSEL, 32'h0000_0000);
    rchk("rsel", REG_RSEL, 32'h0000_0005);
    rchk("tq", REG_TQ, 32'hC8C8_C8C8);
    rchk("fmax", REG_FMAX, 32'h0000_1770);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(er));
    $display("test reset and registers done");
    drv.run <= 1'b1;
    ochk("running", 5'h1F);
    drv.run <= 1'b0;
    drv.dcbrake <= 1'b1;
    ochk("dc braking", 5'h1F);
    drv.dcbrake <= 1'b0;
    apb(1'b1, REG_CFG, 32'h0000_0021);
    ochk("polarity", 5'h01);
    drv.trip <= 1'b1;
    relchk(1'b0);
    apb(1'b1, REG_CFG, 32'h0000_0001);
    relchk(1'b1);
    drv.trip <= 1'b0;
    relchk(1'b0);
    $display("test run indicator and relay done");
    apb(1'b1, REG_CFG, 32'h0000_0020);
    apb(1'b1, REG_TSEL, 32'h1960_6081);
    apb(1'b1, REG_THR1, 32'h07D0_0BB8);
    apb(1'b1, REG_THR2, 32'h0000_0BB8);
    drv.fset <= 16'h0FA0;
    drv.run <= 1'b1;
    foreach (fa_tab[k]) begin
      @(posedge I_CLK);
      drv.accel <= ~fa_tab[k][21];
      drv.decel <= fa_tab[k][21];
      drv.fout <= fa_tab[k][20:5];
      ochk("arrival", fa_tab[k][4:0]);
    end
    chk("brake applied", 32'h0000_0001, 32'(brake));
    $display("test arrival done");
    drv.run <= 1'b0;
    apb(1'b1, REG_CFG, 32'h0000_0320);
    apb(1'b1, REG_TSEL, 32'h0000_0007);
    apb(1'b1, REG_TQ, 32'h0A14_1E28);
    foreach (tq_tab[k]) begin
      @(posedge I_CLK);
      drv.reverse <= tq_tab[k][11];
      drv.torque <= tq_tab[k][10:1];
      ochk("overtorque", {4'h0, tq_tab[k][0]});
    end
    drv.torque <= 10'h029;
    drv.reverse <= 1'b0;
    apb(1'b1, REG_CFG, 32'h0000_0020);
    ochk("overtorque no vector", 5'h00);
    rchk("stat", REG_STAT, 32'h0000_0800);
    apb(1'b1, REG_TQ, 32'hFFFF_FFFF);
    rchk("tq saturate", REG_TQ, 32'hC8C8_C8C8);
    $display("test overtorque done");
    I_LARGE_RATING <= 1'b1;
    I_RST <= 1'b1;
    repeat (19) @(posedge I_CLK);
    @(negedge I_CLK);
    chk("relay unpowered", 32'h0000_0001,
        32'({O_RELAY_FIRST, O_RELAY_SECOND}));
    @(posedge I_CLK);
    I_RST <= 1'b0;
    rchk("tq large", REG_TQ, 32'hB4B4_B4B4);
    $display("test large rating done");
    conclude();
  end
endmodule
